// ==== oag_pkg.sv ====
// shared types and constants for the operand address generator
package oag_pkg;

  localparam logic [1:0]  SZ_BYTE  = 2'h0;
  localparam logic [1:0]  SZ_WORD  = 2'h1;
  localparam logic [1:0]  SZ_LONG  = 2'h2;

  localparam logic [3:0]  MD_REG_DIRECT = 4'h0;
  localparam logic [3:0]  MD_REG_IND    = 4'h1;
  localparam logic [3:0]  MD_IND_DISP16 = 4'h2;
  localparam logic [3:0]  MD_IND_DISP24 = 4'h3;
  localparam logic [3:0]  MD_POST_INC   = 4'h4;
  localparam logic [3:0]  MD_PRE_DEC    = 4'h5;
  localparam logic [3:0]  MD_ABS8       = 4'h6;
  localparam logic [3:0]  MD_ABS16      = 4'h7;
  localparam logic [3:0]  MD_ABS24      = 4'h8;
  localparam logic [3:0]  MD_IMM        = 4'h9;
  localparam logic [3:0]  MD_PC_REL8    = 4'ha;
  localparam logic [3:0]  MD_PC_REL16   = 4'hb;
  localparam logic [3:0]  MD_MEM_IND    = 4'hc;

  localparam logic [15:0] ABS8_UPPER    = 16'hff00;
  localparam logic [15:0] MEM_IND_UPPER = 16'h0000;
  localparam int unsigned RESET_EA      = 0;

  // bus cycle lengths in states
  localparam logic [1:0]  STATES_TWO    = 2'h2;
  localparam logic [1:0]  STATES_THREE  = 2'h3;

  typedef struct packed {
    logic        start;
    logic [3:0]  mode;
    logic [1:0]  size;
    logic [3:0]  reg_sel;
    logic [31:0] ext;
    logic [7:0]  op_code;
  } oag_req_s;

  typedef struct packed {
    logic        is_periph;
    logic        path16;
    logic        three_state;
  } oag_cfg_s;

endpackage

// ==== oag_bus_seq.sv ====
// bus cycle sequencer toward on-chip memory and peripheral registers
`timescale 1ns/10ps
module oag_bus_seq (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             go,
  input  wire logic [15:0]      addr,
  input  wire logic             is_word,
  input  wire oag_pkg::oag_cfg_s cfg,
  output logic                  busy,
  output logic                  strobe,
  output logic [15:0]           bus_addr,
  output logic                  bus_word,
  output logic                  done,
  output logic                  refused
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_T1   = 4'h2,
    ST_T2   = 4'h4,
    ST_T3   = 4'h8
  } oag_bus_e;

  oag_bus_e    state_ff, nxt_state;
  logic [15:0] addr_ff, nxt_addr;
  logic        word_ff, nxt_word;
  logic        split_ff, nxt_split;
  logic        three_ff, nxt_three;
  logic        done_ff, nxt_done;
  logic        ref_ff, nxt_ref;
  logic        strobe_ff, nxt_strobe;

  always_comb begin
    nxt_state = state_ff;
    nxt_addr  = addr_ff;
    nxt_word  = word_ff;
    nxt_split = split_ff;
    nxt_three = three_ff;
    nxt_done  = 1'b0;
    nxt_ref   = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (go) begin
          // byte access to a 16-bit peripheral register is not allowed
          if (cfg.is_periph && cfg.path16 && !is_word) begin
            nxt_ref  = 1'b1;
            nxt_done = 1'b1;
          end else begin
            nxt_state = ST_T1;
            nxt_addr  = addr;
            nxt_three = cfg.is_periph && cfg.three_state;
            // word on an 8-bit register splits into two byte cycles
            nxt_split = cfg.is_periph && !cfg.path16 && is_word;
            nxt_word  = is_word && !(cfg.is_periph && !cfg.path16);
          end
        end
      end
      ST_T1: nxt_state = ST_T2;
      ST_T2: begin
        if (three_ff) begin
          nxt_state = ST_T3;
        end else if (split_ff) begin
          nxt_split = 1'b0;
          nxt_addr  = addr_ff + 16'h0001;
          nxt_state = ST_T1;
        end else begin
          nxt_state = ST_IDLE;
          nxt_done  = 1'b1;
        end
      end
      ST_T3: begin
        if (split_ff) begin
          nxt_split = 1'b0;
          nxt_addr  = addr_ff + 16'h0001;
          nxt_state = ST_T1;
        end else begin
          nxt_state = ST_IDLE;
          nxt_done  = 1'b1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      addr_ff  <= 16'h0000;
      word_ff  <= 1'b0;
      split_ff <= 1'b0;
      three_ff <= 1'b0;
      done_ff  <= 1'b0;
      ref_ff   <= 1'b0;
      strobe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      word_ff  <= nxt_word;
      split_ff <= nxt_split;
      three_ff <= nxt_three;
      done_ff  <= nxt_done;
      ref_ff   <= nxt_ref;
      strobe_ff <= nxt_strobe;
    end
  end

  assign busy     = (state_ff != ST_IDLE);
  // strobe leaves a flop so the top output carries no decode glitch
  assign nxt_strobe = (nxt_state == ST_T1);
  assign strobe   = strobe_ff;
  assign bus_addr = addr_ff;
  assign bus_word = word_ff;
  assign done     = done_ff;
  assign refused  = ref_ff;

  a_two_state_mem: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == ST_T1 && !three_ff && !split_ff) |=> (state_ff == ST_T2) ##1 done_ff)
    else $error("two-state cycle did not finish on time");
  a_three_state: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == ST_T2 && three_ff) |=> (state_ff == ST_T3))
    else $error("three-state cycle skipped its third state");
  a_split_word: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == ST_T2 && split_ff && !three_ff) |=> (state_ff == ST_T1)
      && addr_ff == $past(addr_ff) + 16'h0001)
    else $error("word on byte path not split");

endmodule

// ==== oag_top.sv ====
// operand effective address generator with bus cycle sequencing
`timescale 1ns/10ps
module oag_top (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire oag_pkg::oag_req_s req,
  input  wire oag_pkg::oag_cfg_s cfg,
  input  wire logic [31:0]       rd_data,
  input  wire logic [23:0]       pc_next,
  output logic                   busy,
  output logic [31:0]            operand,
  output logic [15:0]            eff_addr,
  output logic [2:0]             bit_num,
  output logic [1:0]             trap_vec,
  output logic [23:0]            branch_target,
  output logic                   result_valid,
  output logic                   bus_strobe,
  output logic [15:0]            bus_addr,
  output logic                   bus_word,
  output logic                   bus_refused
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_BUS   = 4'h2,
    ST_WRBK  = 4'h4,
    ST_PTR   = 4'h8
  } oag_top_e;

  // register file: eight longword address/data registers
  logic [31:0] regs_ff [0:7];
  logic [31:0] nxt_reg_val;
  logic [2:0]  nxt_reg_idx;
  logic        nxt_reg_we;

  oag_top_e    state_ff, nxt_state;
  logic [31:0] operand_ff, nxt_operand;
  logic [15:0] ea_ff, nxt_ea;
  logic [2:0]  bit_ff, nxt_bit;
  logic [1:0]  trap_ff, nxt_trap;
  logic [23:0] tgt_ff, nxt_tgt;
  logic        valid_ff, nxt_valid;
  logic [2:0]  ridx_ff, nxt_ridx;
  logic [31:0] wb_ff, nxt_wb;
  logic        go_ff, nxt_go;
  logic        word_ff, nxt_word;
  logic        wb_pending_ff, nxt_wb_pending;
  logic        busy_ff, nxt_busy;

  logic        seq_busy;
  logic        seq_done;
  logic        seq_ref;

  function automatic logic [31:0] step_of(input logic [1:0] sz);
    case (sz)
      oag_pkg::SZ_BYTE: step_of = 32'h0000_0001;
      oag_pkg::SZ_WORD: step_of = 32'h0000_0002;
      default:          step_of = 32'h0000_0004;
    endcase
  endfunction

  // low 16 of a 24-bit address: upper eight bits always dropped
  function automatic logic [15:0] trim(input logic [31:0] a);
    trim = a[15:0];
  endfunction

  // register direct read by size: 4-bit field for byte/word, 3-bit for long
  function automatic logic [31:0] reg_direct(input logic [3:0] sel, input logic [1:0] sz,
                                             input logic [31:0] r);
    case (sz)
      oag_pkg::SZ_BYTE: reg_direct = sel[3] ? {24'h000000, r[7:0]} : {24'h000000, r[15:8]};
      oag_pkg::SZ_WORD: reg_direct = sel[3] ? {16'h0000, r[31:16]} : {16'h0000, r[15:0]};
      default:          reg_direct = r;
    endcase
  endfunction

  logic [31:0] rsel;
  assign rsel = regs_ff[req.reg_sel[2:0]];

  always_comb begin
    nxt_state   = state_ff;
    nxt_operand = operand_ff;
    nxt_ea      = ea_ff;
    nxt_bit     = bit_ff;
    nxt_trap    = trap_ff;
    nxt_tgt     = tgt_ff;
    nxt_valid   = 1'b0;
    nxt_ridx    = ridx_ff;
    nxt_wb      = wb_ff;
    nxt_go      = 1'b0;
    nxt_word    = word_ff;
    nxt_reg_we  = 1'b0;
    nxt_reg_idx = ridx_ff;
    nxt_reg_val = wb_ff;
    case (state_ff)
      ST_IDLE: begin
        if (req.start) begin
          nxt_ridx = req.reg_sel[2:0];
          nxt_bit  = req.op_code[6:4];
          nxt_trap = req.op_code[5:4];
          nxt_word = (req.size != oag_pkg::SZ_BYTE);
          nxt_go   = 1'b1;
          nxt_state = ST_BUS;
          case (req.mode)
            oag_pkg::MD_REG_DIRECT: begin
              nxt_operand = reg_direct(req.reg_sel, req.size, rsel);
              nxt_valid   = 1'b1;
              nxt_go      = 1'b0;
              nxt_state   = ST_IDLE;
            end
            oag_pkg::MD_REG_IND: nxt_ea = trim({8'h00, rsel[23:0]});
            oag_pkg::MD_IND_DISP16:
              nxt_ea = trim(rsel + {{16{req.ext[15]}}, req.ext[15:0]});
            oag_pkg::MD_IND_DISP24:
              nxt_ea = trim(rsel + {8'h00, req.ext[23:0]});
            oag_pkg::MD_POST_INC: begin
              nxt_ea = trim(rsel);
              nxt_wb = rsel + step_of(req.size);
            end
            oag_pkg::MD_PRE_DEC: begin
              nxt_ea = trim(rsel - step_of(req.size));
              nxt_reg_we  = 1'b1;
              nxt_reg_idx = req.reg_sel[2:0];
              nxt_reg_val = rsel - step_of(req.size);
            end
            oag_pkg::MD_ABS8: nxt_ea = oag_pkg::ABS8_UPPER | {8'h00, req.ext[7:0]};
            oag_pkg::MD_ABS16:
              nxt_ea = trim({{16{req.ext[15]}}, req.ext[15:0]});
            oag_pkg::MD_ABS24: nxt_ea = trim({8'h00, req.ext[23:0]});
            oag_pkg::MD_IMM: begin
              case (req.size)
                oag_pkg::SZ_BYTE: nxt_operand = {24'h000000, req.ext[7:0]};
                oag_pkg::SZ_WORD: nxt_operand = {16'h0000, req.ext[15:0]};
                default:          nxt_operand = req.ext;
              endcase
              nxt_valid = 1'b1;
              nxt_go    = 1'b0;
              nxt_state = ST_IDLE;
            end
            oag_pkg::MD_PC_REL8: begin
              nxt_tgt   = pc_next + {{16{req.ext[7]}}, req.ext[7:0]};
              nxt_ea    = trim({8'h00, nxt_tgt});
              nxt_valid = 1'b1;
              nxt_go    = 1'b0;
              nxt_state = ST_IDLE;
            end
            oag_pkg::MD_PC_REL16: begin
              nxt_tgt   = pc_next + {{8{req.ext[15]}}, req.ext[15:0]};
              nxt_ea    = trim({8'h00, nxt_tgt});
              nxt_valid = 1'b1;
              nxt_go    = 1'b0;
              nxt_state = ST_IDLE;
            end
            oag_pkg::MD_MEM_IND: begin
              // pointer table lives in the low page, fetched as one word access, or as two byte cycles on an 8-bit register
              nxt_ea    = oag_pkg::MEM_IND_UPPER | {8'h00, req.ext[7:0]};
              nxt_word  = 1'b1;
              nxt_state = ST_PTR;
            end
            default: begin
              nxt_go    = 1'b0;
              nxt_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_BUS, ST_PTR: begin
        if (seq_done) begin
          nxt_operand = rd_data;
          if (state_ff == ST_PTR) begin
            nxt_tgt = rd_data[23:0];
          end
          nxt_valid = 1'b1;
          nxt_state = ST_IDLE;
          if (wb_pending_ff) begin
            nxt_state = ST_WRBK;
            nxt_valid = 1'b0;
          end
        end
      end
      ST_WRBK: begin
        // write back only after the access so the old address was used
        nxt_reg_we  = 1'b1;
        nxt_reg_idx = ridx_ff;
        nxt_reg_val = wb_ff;
        nxt_valid   = 1'b1;
        nxt_state   = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_comb begin
    nxt_wb_pending = wb_pending_ff;
    if (state_ff == ST_IDLE && req.start) begin
      nxt_wb_pending = (req.mode == oag_pkg::MD_POST_INC);
    end else if (state_ff == ST_WRBK) begin
      nxt_wb_pending = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff      <= ST_IDLE;
      operand_ff    <= 32'h0000_0000;
      ea_ff         <= 16'h0000;
      bit_ff        <= 3'h0;
      trap_ff       <= 2'h0;
      tgt_ff        <= 24'h000000;
      valid_ff      <= 1'b0;
      ridx_ff       <= 3'h0;
      wb_ff         <= 32'h0000_0000;
      go_ff         <= 1'b0;
      word_ff       <= 1'b0;
      wb_pending_ff <= 1'b0;
      busy_ff       <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        regs_ff[i] <= 32'h0000_0000;
      end
    end else begin
      state_ff      <= nxt_state;
      operand_ff    <= nxt_operand;
      ea_ff         <= nxt_ea;
      bit_ff        <= nxt_bit;
      trap_ff       <= nxt_trap;
      tgt_ff        <= nxt_tgt;
      valid_ff      <= nxt_valid;
      ridx_ff       <= nxt_ridx;
      wb_ff         <= nxt_wb;
      go_ff         <= nxt_go;
      word_ff       <= nxt_word;
      wb_pending_ff <= nxt_wb_pending;
      busy_ff       <= nxt_busy;
      if (nxt_reg_we) begin
        regs_ff[nxt_reg_idx] <= nxt_reg_val;
      end
    end
  end

  oag_bus_seq u_seq (
    .clock    (clock),
    .reset_n  (reset_n),
    .go       (go_ff),
    .addr     (ea_ff),
    .is_word  (word_ff),
    .cfg      (cfg),
    .busy     (seq_busy),
    .strobe   (bus_strobe),
    .bus_addr (bus_addr),
    .bus_word (bus_word),
    .done     (seq_done),
    .refused  (bus_refused)
  );

  // busy comes from its own flop so no decode glitch reaches the pin
  assign nxt_busy      = (nxt_state != ST_IDLE);
  assign busy          = busy_ff;
  assign operand       = operand_ff;
  assign eff_addr      = ea_ff;
  assign bit_num       = bit_ff;
  assign trap_vec      = trap_ff;
  assign branch_target = tgt_ff;
  assign result_valid  = valid_ff;

  a_abs8_upper: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == ST_IDLE && req.start && req.mode == oag_pkg::MD_ABS8)
      |=> ea_ff[15:8] == 8'hff)
    else $error("short absolute address not in top page");
  a_memind_low: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == ST_IDLE && req.start && req.mode == oag_pkg::MD_MEM_IND)
      |=> ea_ff[15:8] == 8'h00 && word_ff)
    else $error("pointer address not in low page");
  a_predec_wb: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == ST_IDLE && req.start && req.mode == oag_pkg::MD_PRE_DEC)
      |=> regs_ff[ridx_ff][15:0] == ea_ff)
    else $error("pre-decrement not written back");
  a_postinc_wb: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == ST_WRBK) |=> regs_ff[ridx_ff] == $past(wb_ff) && result_valid)
    else $error("post-increment sum not stored");
  a_ptr_target: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == ST_PTR && seq_done) |=> branch_target == $past(rd_data[23:0]))
    else $error("pointer target bytes wrong");
  a_imm_done: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == ST_IDLE && req.start && req.mode == oag_pkg::MD_IMM)
      |=> result_valid && !busy)
    else $error("immediate operand not immediate");
  a_seq_idle: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == ST_IDLE) |-> !seq_busy)
    else $error("bus sequencer active while generator idle");

endmodule

// ==== oag_mem_model.sv ====
// behavioural on-chip memory and peripheral register contents
`timescale 1ns/10ps
module oag_mem_model (
  input  wire logic        busy,
  input  wire logic [15:0] bus_addr,
  output logic [31:0]      rd_data
);
  logic [31:0] contents;

  // top byte is junk on purpose so a target that keeps it shows up
  assign contents = {8'hc3, bus_addr[7:0] ^ 8'h5a, bus_addr};

  // outside a transfer the data lines carry no valid value
  always_comb begin
    if (busy) begin
      rd_data = contents;
    end else begin
      rd_data = ~contents;
    end
  end
endmodule

// ==== testbench.sv ====
// self-checking bench for the operand address generator
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  logic              clock;
  logic              reset_n;
  oag_pkg::oag_req_s req;
  oag_pkg::oag_cfg_s cfg;
  logic [31:0]       rd_data;
  logic [31:0]       operand;
  logic [23:0]       pc_next;
  logic [23:0]       branch_target;
  logic              busy;
  logic              result_valid;
  logic              bus_strobe;
  logic              bus_word;
  logic              bus_refused;
  logic [15:0]       eff_addr;
  logic [15:0]       bus_addr;
  logic [2:0]        bit_num;
  logic [1:0]        trap_vec;
  int                failures;
  int                comparisons;
  int                lat;
  int                base;
  logic [15:0]       sq[$];
  logic              wq[$];
  logic              refused_seen;

  oag_top u_dut (.clock(clock), .reset_n(reset_n), .req(req), .cfg(cfg), .rd_data(rd_data),
    .pc_next(pc_next), .busy(busy), .operand(operand), .eff_addr(eff_addr), .bit_num(bit_num),
    .trap_vec(trap_vec), .branch_target(branch_target), .result_valid(result_valid),
    .bus_strobe(bus_strobe), .bus_addr(bus_addr), .bus_word(bus_word),
    .bus_refused(bus_refused));

  oag_mem_model u_mem (.busy(busy), .bus_addr(bus_addr), .rd_data(rd_data));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    if (bus_strobe === 1'b1) begin
      sq.push_back(bus_addr);
      wq.push_back(bus_word);
    end
    if (bus_refused === 1'b1) begin
      refused_seen = 1'b1;
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // cfg is the per-address width and state table, held for the whole request
  task automatic op(input logic [3:0] md, input logic [1:0] sz, input logic [3:0] rs,
                    input logic [31:0] ex, input logic [2:0] cf);
    @(posedge clock);
    #1;
    sq.delete();
    wq.delete();
    refused_seen = 1'b0;
    req.start = 1'b1;
    req.mode = md;
    req.size = sz;
    req.reg_sel = rs;
    req.ext = ex;
    cfg = oag_pkg::oag_cfg_s'(cf);
    @(posedge clock);
    #1;
    req.start = 1'b0;
    lat = 0;
    while (result_valid !== 1'b1 && lat < 40) begin
      @(posedge clock);
      #1;
      lat++;
    end
    if (lat >= 40) begin
      failures++;
      $display("CHECK FAILED result_valid expected 1 seen 0");
    end
    `CHK("idle after result", 1'b0, busy)
  endtask

  task automatic t_imm();
    logic [1:0]  sz[3] = '{oag_pkg::SZ_BYTE, oag_pkg::SZ_WORD, oag_pkg::SZ_LONG};
    logic [31:0] mk[3] = '{32'h0000_00ff, 32'h0000_ffff, 32'hffff_ffff};
    req.op_code = 8'h5a;
    for (int i = 0; i < 3; i++) begin
      op(oag_pkg::MD_IMM, sz[i], 4'h0, 32'h1234_56a7, 3'h0);
      `CHK("imm latency", 0, lat)
      `CHK("imm operand", 32'h1234_56a7 & mk[i], operand & mk[i])
    end
    `CHK("bit number", 3'h5, bit_num)
    `CHK("trap vector", 2'h1, trap_vec)
  endtask

  // even register values only for word and longword steps
  task automatic t_step();
    logic [3:0]  md[7] = '{oag_pkg::MD_PRE_DEC, oag_pkg::MD_PRE_DEC, oag_pkg::MD_PRE_DEC,
      oag_pkg::MD_POST_INC, oag_pkg::MD_POST_INC, oag_pkg::MD_POST_INC, oag_pkg::MD_REG_IND};
    logic [1:0]  sz[7] = '{oag_pkg::SZ_WORD, oag_pkg::SZ_LONG, oag_pkg::SZ_BYTE,
      oag_pkg::SZ_BYTE, oag_pkg::SZ_LONG, oag_pkg::SZ_WORD, oag_pkg::SZ_WORD};
    logic [15:0] ea[7] = '{16'hfffe, 16'hfffa, 16'hfff9, 16'hfff9, 16'hfffa, 16'hfffe,
      16'h0000};
    for (int i = 0; i < 7; i++) begin
      op(md[i], sz[i], 4'h1, 32'h0, 3'h0);
      `CHK("step address", ea[i], eff_addr)
      `CHK("step strobes", 1, sq.size())
      if (sq.size() > 0) `CHK("step bus address", ea[i], sq[0])
    end
    `CHK("memory read", {8'hc3, 8'h5a, 16'h0000}, operand)
  endtask

  // register 2 is pre-decremented from zero first, so both displacement sums wrap past 32 bits
  task automatic t_disp();
    op(oag_pkg::MD_PRE_DEC, oag_pkg::SZ_WORD, 4'h2, 32'h0, 3'h0);
    op(oag_pkg::MD_IND_DISP16, oag_pkg::SZ_BYTE, 4'h2, 32'h0000_0010, 3'h0);
    `CHK("disp16 address", 16'h000e, eff_addr)
    op(oag_pkg::MD_IND_DISP24, oag_pkg::SZ_BYTE, 4'h2, 32'h00ab_0100, 3'h0);
    `CHK("disp24 address", 16'h00fe, eff_addr)
  endtask

  task automatic t_abs_regdir();
    logic [3:0]  am[3] = '{oag_pkg::MD_ABS8, oag_pkg::MD_ABS16, oag_pkg::MD_ABS24};
    logic [15:0] ae[3] = '{16'hff34, 16'h8001, 16'habcd};
    logic [1:0]  rz[5] = '{oag_pkg::SZ_LONG, oag_pkg::SZ_WORD, oag_pkg::SZ_WORD,
      oag_pkg::SZ_BYTE, oag_pkg::SZ_BYTE};
    logic [3:0]  rr[5] = '{4'h2, 4'ha, 4'h2, 4'ha, 4'h2};
    logic [31:0] rv[5] = '{32'hffff_fffe, 32'hffff, 32'hfffe, 32'hfe, 32'hff};
    logic [31:0] rm[5] = '{32'hffff_ffff, 32'hffff, 32'hffff, 32'hff, 32'hff};
    logic [31:0] ax[3] = '{32'h0000_1234, 32'h0000_8001, 32'h0012_abcd};
    for (int i = 0; i < 3; i++) begin
      op(am[i], oag_pkg::SZ_BYTE, 4'h0, ax[i], 3'h0);
      `CHK("absolute address", ae[i], eff_addr)
    end
    for (int i = 0; i < 5; i++) begin
      op(oag_pkg::MD_REG_DIRECT, rz[i], rr[i], 32'h0, 3'h0);
      `CHK("register operand", rv[i], operand & rm[i])
    end
  endtask

  task automatic t_branch();
    pc_next = 24'h001000;
    op(oag_pkg::MD_PC_REL8, oag_pkg::SZ_BYTE, 4'h0, 32'h0000_0080, 3'h0);
    `CHK("rel8 back", 24'h000f80, branch_target)
    op(oag_pkg::MD_PC_REL8, oag_pkg::SZ_BYTE, 4'h0, 32'h0000_007e, 3'h0);
    `CHK("rel8 forward", 24'h00107e, branch_target)
    op(oag_pkg::MD_PC_REL16, oag_pkg::SZ_WORD, 4'h0, 32'h0000_8000, 3'h0);
    `CHK("rel16 back", 24'hff9000, branch_target)
    op(oag_pkg::MD_MEM_IND, oag_pkg::SZ_LONG, 4'h0, 32'h0000_ff40, 3'h0);
    `CHK("pointer address", 16'h0040, eff_addr)
    `CHK("pointer fetches", 1, sq.size())
    `CHK("indirect target", 24'h1a0040, branch_target)
  endtask

  // cfg bits: is_periph, path16, three_state
  task automatic t_periph();
    op(oag_pkg::MD_ABS16, oag_pkg::SZ_BYTE, 4'h0, 32'h0000_ff90, 3'b000);
    base = lat;
    op(oag_pkg::MD_ABS16, oag_pkg::SZ_WORD, 4'h0, 32'h0000_ff90, 3'b000);
    `CHK("memory word latency", base, lat)
    `CHK("memory word flag", 1'b1, wq[0])
    op(oag_pkg::MD_ABS16, oag_pkg::SZ_BYTE, 4'h0, 32'h0000_ff90, 3'b100);
    `CHK("two state latency", base, lat)
    op(oag_pkg::MD_ABS16, oag_pkg::SZ_BYTE, 4'h0, 32'h0000_ff90, 3'b101);
    `CHK("three state latency", base + 1, lat)
    op(oag_pkg::MD_ABS16, oag_pkg::SZ_WORD, 4'h0, 32'h0000_ff90, 3'b100);
    `CHK("split latency", base + 2, lat)
    `CHK("split strobes", 2, sq.size())
    if (sq.size() == 2) begin
      `CHK("split first", 16'hff90, sq[0])
      `CHK("split second", 16'hff91, sq[1])
    end
    op(oag_pkg::MD_ABS16, oag_pkg::SZ_WORD, 4'h0, 32'h0000_ffa0, 3'b110);
    `CHK("wide word strobes", 1, sq.size())
    `CHK("wide word refused", 1'b0, refused_seen)
    op(oag_pkg::MD_ABS16, oag_pkg::SZ_BYTE, 4'h0, 32'h0000_ffa0, 3'b110);
    `CHK("wide byte refused", 1'b1, refused_seen)
    `CHK("wide byte strobes", 0, sq.size())
  endtask

  initial begin
    #(3000 * 50);
    failures++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    wrap_up();
  end

  initial begin
    failures = 0;
    comparisons = 0;
    reset_n = 1'b0;
    req = '0;
    cfg = '0;
    pc_next = 24'h0;
    repeat (12) @(posedge clock);
    `CHK("busy in reset", 1'b0, busy)
    `CHK("valid in reset", 1'b0, result_valid)
    #1;
    reset_n = 1'b1;
    t_imm();
    t_step();
    t_disp();
    t_abs_regdir();
    t_branch();
    t_periph();
    wrap_up();
  end
endmodule
